// ---- hdl/ccm_pkg.sv ----
// Behaviour
// - Mode 0000 disables unit, holds reset state
// - Capture on falling, rising, 4th, 16th edge
// - Mode 1000 match drives output high, flag
// - Mode 1001 match drives output low, flag
// - Mode 1010 match sets flag only
// - Mode 1011 match flags, clears timer1, conversion
// - Capture copies full 16-bit timer1 count
// - Capture sets interrupt flag bit 2
// - Flag cleared only by software write
// - Newer capture overwrites unread value
// - Pin sampled whatever the port direction
// - Mode change may raise false flag
// - Prescaler cleared when off or not capture
// - Prescaler kept across prescaler switches
// - Mode bits 3:0, duty 5:4, 7:6 zero
// - Capture value built from two byte halves
package ccm_pkg;
  // Register byte offsets on the slave bus
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_VLOW  = 5'h04;
  localparam logic [4:0] OFS_VHIGH = 5'h08;
  localparam logic [4:0] OFS_FLAG  = 5'h0c;
  localparam logic [4:0] OFS_IEN   = 5'h10;
  // Field positions
  localparam int FLAG_BIT = 2;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] VAL_RST  = 16'h0000;
  localparam logic [3:0]  PSC_RST  = 4'h0;
  // Mode codes
  typedef enum logic [3:0] {
    M_OFF   = 4'b0000,
    M_FALL  = 4'b0100,
    M_RISE  = 4'b0101,
    M_RISE4 = 4'b0110,
    M_RISE16= 4'b0111,
    M_CSET  = 4'b1000,
    M_CCLR  = 4'b1001,
    M_CSWI  = 4'b1010,
    M_CSPEC = 4'b1011
  } ccm_mode_t;
  // Prescaler terminal counts
  localparam logic [3:0] PSC_LAST4  = 4'h3;
  localparam logic [3:0] PSC_LAST16 = 4'hf;
endpackage

// ---- hdl/ccm_top.sv ----
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ccm_top
  import ccm_pkg::*;
#(
  parameter bit SECOND_UNIT = 1'b0 // Second unit also starts conversions
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Event pin and time base
  input  wire logic        unit_event_pin,
  input  wire logic [15:0] timer1_count,
  input  wire logic        adc_enabled,
  // Outputs to neighbours
  output logic             compare_out,
  output logic             timer1_clear,
  output logic             adc_start,
  output logic             pwm_select
);

  // Bus state
  logic        wait_r, wait_nxt;       // Waitrequest flop
  logic [31:0] rdata_r, rdata_nxt;     // Read data flop
  // Software registers
  logic [7:0]  ctrl_r, ctrl_nxt;       // unit_control_reg
  logic [7:0]  vlow_r, vlow_nxt;       // capture_value_low
  logic [7:0]  vhigh_r, vhigh_nxt;     // capture_value_high
  logic        flag_r, flag_nxt;       // unit_irq_flag
  logic        ien_r, ien_nxt;         // unit_irq_enable
  // Core state
  logic        sync1_r, sync2_r, prev_r; // Pin synchroniser and history
  logic [3:0]  psc_r, psc_nxt;         // Capture prescaler counter
  logic        match_r, match_nxt;     // Match seen last cycle
  logic        out_r, out_nxt;         // Compare output latch
  logic        tclr_r, tclr_nxt;       // Timer clear pulse
  logic        adc_r, adc_nxt;         // Conversion start pulse
  logic        pwm_r, pwm_nxt;         // Pulse-width selection
  // Decode
  logic        go, wr_go;              // Accepted access
  logic [3:0]  mode;                   // mode_select_field
  logic        is_cap, is_cmp;         // Mode class
  logic        rise, fall;             // Pin edges
  logic        cap_ev, hit, clr_wr;    // Events

  // Mode field in low bits
  assign mode   = ctrl_r[3:0];
  assign is_cap = (mode[3:2] == 2'b01);
  assign is_cmp = (mode[3:2] == 2'b10);
  // Access is taken when waitrequest is low
  assign go     = (avs_read | avs_write) & ~wait_r;
  assign wr_go  = go & avs_write;
  // Edges from the synchronised pin; direction not considered
  assign rise   = sync2_r & ~prev_r;
  assign fall   = ~sync2_r & prev_r;
  // Match on the combined byte pair, once per entry into equality
  assign hit    = is_cmp & match_nxt & ~match_r;
  assign clr_wr = wr_go & (avs_address == OFS_FLAG) & avs_byteenable[0]
                  & avs_writedata[FLAG_BIT];

  // Byte lane test shared by writes
  function automatic logic lane0(input logic [4:0] a, input logic [4:0] o);
    lane0 = wr_go & (a == o) & avs_byteenable[0];
  endfunction

  // Capture event selection and prescaler
  always_comb begin
    psc_nxt = psc_r;
    cap_ev  = 1'b0;
    unique case (mode)
      // No prescaler on the single edge settings
      M_FALL: begin
        cap_ev = fall;
      end
      M_RISE: begin
        cap_ev = rise;
      end
      M_RISE4: begin
        // Low bits only, so a count left by another setting is kept
        if (rise) begin
          psc_nxt = psc_r + 4'h1;
          cap_ev  = (psc_r[1:0] == PSC_LAST4[1:0]);
          if (cap_ev) begin
            psc_nxt = PSC_RST;
          end
        end
      end
      // Counter wraps by itself after sixteen rises
      M_RISE16: begin
        if (rise) begin
          psc_nxt = psc_r + 4'h1;
          cap_ev  = (psc_r == PSC_LAST16);
        end
      end
      default: begin
        // Off, compare and pulse-width clear the prescaler
        psc_nxt = PSC_RST;
      end
    endcase
  end

  // Compare actions and mode outputs
  always_comb begin
    // Same-clock time base, read without synchronisers
    match_nxt = is_cmp & (timer1_count == {vhigh_r, vlow_r});
    out_nxt   = out_r;
    tclr_nxt  = 1'b0;
    adc_nxt   = 1'b0;
    pwm_nxt   = (mode[3:2] == 2'b11);
    // Off mode forces the compare latch low
    if (mode == M_OFF) begin
      out_nxt = 1'b0;
    end else if (hit) begin
      unique case (mode)
        M_CSET: out_nxt = 1'b1;
        M_CCLR: out_nxt = 1'b0;
        M_CSWI: out_nxt = out_r;
        default: begin
          // Special event leaves the pin alone
          tclr_nxt = 1'b1;
          adc_nxt  = SECOND_UNIT & adc_enabled;
        end
      endcase
    end
  end

  // Register file and bus answer
  always_comb begin
    // Waitrequest drops for one cycle per access, then rises again
    wait_nxt  = ~((avs_read | avs_write) & wait_r);
    rdata_nxt = 32'h0000_0000;
    ctrl_nxt  = ctrl_r;
    vlow_nxt  = vlow_r;
    vhigh_nxt = vhigh_r;
    ien_nxt   = ien_r;
    flag_nxt  = flag_r;
    // Read data prepared while waitrequest is high
    if (avs_read & wait_r) begin
      unique case (avs_address)
        OFS_CTRL:  rdata_nxt = {24'h000000, ctrl_r};
        OFS_VLOW:  rdata_nxt = {24'h000000, vlow_r};
        OFS_VHIGH: rdata_nxt = {24'h000000, vhigh_r};
        OFS_FLAG:  rdata_nxt = {29'h0, flag_r, 2'h0};
        OFS_IEN:   rdata_nxt = {29'h0, ien_r, 2'h0};
        // Unmapped addresses read as zero
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
    // Upper control bits are not stored
    if (lane0(avs_address, OFS_CTRL)) begin
      ctrl_nxt = {2'b00, avs_writedata[5:0]};
    end
    // Separate byte halves of the capture value
    if (lane0(avs_address, OFS_VLOW)) begin
      vlow_nxt = avs_writedata[7:0];
    end
    if (lane0(avs_address, OFS_VHIGH)) begin
      vhigh_nxt = avs_writedata[7:0];
    end
    // Enable bit is only stored; no interrupt line leaves this block
    if (lane0(avs_address, OFS_IEN)) begin
      ien_nxt = avs_writedata[FLAG_BIT];
    end
    // A capture wins over a software write; older value is lost
    if (is_cap & cap_ev) begin
      {vhigh_nxt, vlow_nxt} = timer1_count;
    end
    // Flag clears on write, but a same-cycle event wins
    if (clr_wr) begin
      flag_nxt = 1'b0;
    end
    // Also set when a mode change lets a stale edge through
    if ((is_cap & cap_ev) | hit) begin
      flag_nxt = 1'b1;
    end
  end

  // All state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Every register back to its reset value
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r  <= CTRL_RST;
      vlow_r  <= VAL_RST[7:0];
      vhigh_r <= VAL_RST[15:8];
      flag_r  <= 1'b0;
      ien_r   <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      psc_r   <= PSC_RST;
      match_r <= 1'b0;
      out_r   <= 1'b0;
      tclr_r  <= 1'b0;
      adc_r   <= 1'b0;
      pwm_r   <= 1'b0;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r  <= ctrl_nxt;
      vlow_r  <= vlow_nxt;
      vhigh_r <= vhigh_nxt;
      flag_r  <= flag_nxt;
      ien_r   <= ien_nxt;
      // Two synchroniser flops, then the history flop for edges
      sync1_r <= unit_event_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      psc_r   <= psc_nxt;
      match_r <= match_nxt;
      out_r   <= out_nxt;
      tclr_r  <= tclr_nxt;
      adc_r   <= adc_nxt;
      pwm_r   <= pwm_nxt;
    end
  end

  // Outputs straight from flops
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign compare_out     = out_r;
  assign timer1_clear    = tclr_r;
  assign adc_start       = adc_r;
  assign pwm_select      = pwm_r;

  // Checks
  // Properties run on the system clock and pause during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_off_out_low: assert property (
    (mode == M_OFF) |=> !out_r)
    else $error("output not low while unit off");
  a_fall_capture: assert property (
    (mode == M_FALL && fall) |=> ({vhigh_r, vlow_r} == $past(timer1_count)) && flag_r)
    else $error("falling edge capture missed");
  // Fourth edge counter steps once per rise below its last count
  a_rise4_count: assert property (
    (mode == M_RISE4 && rise && psc_r[1:0] != PSC_LAST4[1:0])
      |=> (psc_r[1:0] == $past(psc_r[1:0]) + 2'b01))
    else $error("fourth edge prescaler skipped a count");
  a_set_match: assert property (
    (mode == M_CSET && hit) |=> out_r && flag_r)
    else $error("set on match failed");
  a_clr_match: assert property (
    (mode == M_CCLR && hit) |=> !out_r && flag_r)
    else $error("clear on match failed");
  a_swi_pin: assert property (
    (mode == M_CSWI && hit) |=> $stable(out_r) && flag_r)
    else $error("software interrupt mode moved the pin");
  a_special_evt: assert property (
    (mode == M_CSPEC && hit) |=> tclr_r && $stable(out_r) ##1 !tclr_r)
    else $error("special event pulse wrong");
  a_flag_sticky: assert property (
    (flag_r && !clr_wr) |=> flag_r)
    else $error("flag dropped without software");
  a_psc_clear: assert property (
    (!is_cap) |=> (psc_r == 4'h0))
    else $error("prescaler not cleared outside capture");
  a_pwm_select: assert property (
    (mode[3:2] == 2'b11) |=> pwm_r && !tclr_r)
    else $error("pulse-width selection wrong");
  a_ctrl_top: assert property (
    ctrl_r[7:6] == 2'b00)
    else $error("unimplemented control bits set");
  // Any capture loads the whole count, a newer one over an older one
  a_cap_overwrite: assert property (
    (is_cap && cap_ev) |=> ({vhigh_r, vlow_r} == $past(timer1_count)) && flag_r)
    else $error("capture did not load the timer count");
  // Rising edge mode takes every rise
  a_rise_capture: assert property (
    (mode == M_RISE && rise) |=> ({vhigh_r, vlow_r} == $past(timer1_count)) && flag_r)
    else $error("rising edge capture missed");
  // Sixteenth edge counter steps once per rise below its last count
  a_rise16_count: assert property (
    (mode == M_RISE16 && rise && psc_r != PSC_LAST16) |=> (psc_r == $past(psc_r) + 4'h1))
    else $error("sixteenth edge prescaler skipped a count");
  // Without a rise the count holds in any capture setting, even across a switch
  a_psc_keep: assert property (
    (is_cap && !rise) |=> $stable(psc_r))
    else $error("prescaler count lost without an edge");
  // Off mode leaves every pulse and selection low
  a_off_quiet: assert property (
    (mode == M_OFF) |=> !tclr_r && !adc_r && !pwm_r && (psc_r == PSC_RST))
    else $error("unit not quiet while off");
  // A clear with no event in the same cycle drops the flag
  a_flag_clear: assert property (
    (clr_wr && !(is_cap && cap_ev) && !hit) |=> !flag_r)
    else $error("flag not cleared by software");
  // Conversion start only rides on the timer clear pulse
  a_adc_pulse: assert property (
    adc_r |-> tclr_r)
    else $error("conversion start without special event");

endmodule

// ---- testbench/ccm_partner.sv ----
`timescale 1ns/1ps
module ccm_partner (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Bench controls
  input  wire logic        pin_lvl,
  input  wire logic        freeze,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  // From the unit
  input  wire logic        timer1_clear,
  // Far side outputs
  output logic             unit_event_pin,
  output logic [15:0]      timer1_count
);
  // Timer on the system clock, never asynchronous counting
  always_ff @(posedge ref_clk) begin
    if (rst)
      timer1_count <= 16'h0000;
    else if (load)
      timer1_count <= load_val;
    else if (timer1_clear)
      timer1_count <= 16'h0000;
    else if (!freeze)
      timer1_count <= timer1_count + 16'h0001;
  end
  // Pin acts as an input driven from outside
  always_ff @(posedge ref_clk) begin
    if (rst)
      unit_event_pin <= 1'b0;
    else
      unit_event_pin <= pin_lvl;
  end
endmodule

// ---- testbench/ccm_top_test.sv ----
`timescale 1ns/1ps
module ccm_top_test;
  import ccm_pkg::*;
  // Bus side
  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  // Far side and neighbours
  logic        unit_event_pin, pin_lvl, freeze, load, adc_enabled;
  logic [15:0] timer1_count, load_val;
  logic        compare_out, timer1_clear, adc_start, pwm_select, saw_clr, saw_adc;
  logic        adc_start2, saw_adc2;
  int          n_fail, tests_run, cyc;
  // Compare modes with the output level each leaves
  ccm_mode_t   cm [5] = '{M_CSET, M_CSWI, M_CCLR, M_CSPEC, M_CSET};
  logic [4:0]  co = 5'b10011;

  ccm_top uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .unit_event_pin(unit_event_pin),
    .timer1_count(timer1_count), .adc_enabled(adc_enabled),
    .compare_out(compare_out), .timer1_clear(timer1_clear),
    .adc_start(adc_start), .pwm_select(pwm_select));
  ccm_partner far (.ref_clk(ref_clk), .rst(rst), .pin_lvl(pin_lvl), .freeze(freeze),
    .load(load), .load_val(load_val), .timer1_clear(timer1_clear),
    .unit_event_pin(unit_event_pin), .timer1_count(timer1_count));
  // Second unit also starts conversions on its special event
  ccm_top #(.SECOND_UNIT(1'b1)) uut2 (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(),
    .avs_waitrequest(), .unit_event_pin(unit_event_pin),
    .timer1_count(timer1_count), .adc_enabled(adc_enabled), .compare_out(),
    .timer1_clear(), .adc_start(adc_start2), .pwm_select());

  // Free running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Sticky pulse monitors and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (timer1_clear === 1'b1) saw_clr <= 1'b1;
    if (adc_start === 1'b1) saw_adc <= 1'b1;
    if (adc_start2 === 1'b1) saw_adc2 <= 1'b1;
    // Run needs under two thousand cycles; ceiling leaves room
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Timer preload, then n full pin pulses
  task automatic ld(input logic [15:0] v);
    load <= 1'b1;
    load_val <= v;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      pin_lvl <= 1'b1;
      repeat (5) @(posedge ref_clk);
      pin_lvl <= 1'b0;
      repeat (5) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask
  // Capture after exactly n pulses, frozen timer value v
  task automatic cap(input logic [3:0] m, input int n, input logic [15:0] v);
    freeze <= 1'b1;
    ld(v);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, {28'h0, m});
    bus(1'b1, OFS_FLAG, 32'h4);
    pulses(n - 1);
    rdc(OFS_FLAG, 32'h0);
    pulses(1);
    rdc(OFS_FLAG, 32'h4);
    rdc(OFS_VLOW, {24'h0, v[7:0]});
    rdc(OFS_VHIGH, {24'h0, v[15:8]});
  endtask

  // Main sequence
  initial begin
    {avs_read, avs_write, pin_lvl, freeze, load, saw_clr, saw_adc, saw_adc2} = '0;
    {avs_address, avs_writedata, load_val, n_fail, tests_run, cyc} = '0;
    adc_enabled = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_VHIGH, 32'h0);
    bus(1'b1, OFS_CTRL, 32'hff);
    rdc(OFS_CTRL, 32'h3f);
    chk(pwm_select, 1'b1);
    bus(1'b1, 5'h14, 32'hff);
    rdc(5'h14, 32'h0);
    cap(M_FALL, 1, 16'h1234);
    cap(M_RISE4, 4, 16'h8001);
    cap(M_RISE16, 16, 16'hc0de);
    cap(M_RISE, 1, 16'h5a3c);
    // Two captures before any read keep the newer one
    ld(16'h7777);
    pulses(1);
    ld(16'h0f0f);
    pulses(1);
    rdc(OFS_VLOW, 32'h0f);
    rdc(OFS_FLAG, 32'h4);
    // Direct prescaler switch keeps the count
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, {28'h0, M_RISE16});
    pulses(2);
    bus(1'b1, OFS_CTRL, {28'h0, M_RISE4});
    bus(1'b1, OFS_FLAG, 32'h4);
    pulses(1);
    rdc(OFS_FLAG, 32'h0);
    pulses(1);
    rdc(OFS_FLAG, 32'h4);
    // Compare modes against value 0x0030, timer running
    bus(1'b1, OFS_VLOW, 32'h30);
    bus(1'b1, OFS_VHIGH, 32'h00);
    freeze <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      saw_clr <= 1'b0;
      ld(16'h0000);
      bus(1'b1, OFS_CTRL, {28'h0, cm[i]});
      bus(1'b1, OFS_FLAG, 32'h4);
      repeat (60) @(posedge ref_clk);
      rdc(OFS_FLAG, 32'h4);
      chk(compare_out, co[i]);
      chk(saw_clr, cm[i] == M_CSPEC);
    end
    chk(saw_adc, 1'b0);
    chk(saw_adc2, 1'b1);
    // Output was left high; off must pull it low one cycle after the write
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({compare_out, pwm_select}, 2'b00);
    wrap_up();
  end
endmodule
